/* verilog/lccc_defs.vh */
/*
 * Register offsets, field positions, reset values and fixed counts of the
 * line charging current compensator.
 * Assumes it is included by bare name from the design files that need it.
 */
`ifndef LCCC_DEFS_VH
`define LCCC_DEFS_VH

// Register byte offsets on the APB slave.
`define LCCC_OFS_CTRL 8'h00
`define LCCC_OFS_XC1 8'h04
`define LCCC_OFS_XC0 8'h08
`define LCCC_OFS_STATUS 8'h0c
`define LCCC_OFS_RECIP1 8'h10
`define LCCC_OFS_RECIP0 8'h14

// Field positions.
`define LCCC_CTRL_EN_BIT 0
`define LCCC_ST_ACTIVE_BIT 0
`define LCCC_ST_BLOCK_BIT 1
`define LCCC_ST_BUSY_BIT 2
`define LCCC_ST_LEVEL_LSB 8

// Reset values and setting limits; reactances are held in units of 0.1 ohm.
`define LCCC_CTRL_RESET 1'b0
`define LCCC_XC_RESET 16'h1388
`define LCCC_XC_MIN 16'h03e8
`define LCCC_XC_MAX 16'h4e20

// Samples in one fundamental period and the divider step count.
`define LCCC_NPER 16
`define LCCC_DIV_STEPS 6'h20

// One third in Q16, used for the zero sequence component.
`define LCCC_THIRD_Q16 16'h5555

`endif

/* verilog/lccc_fifo.v */
/*
 * Synchronous FIFO with valid and ready on both sides; the head word is
 * held in an output register.
 * Assumes one clock and an active low asynchronous reset.
 */
`timescale 1ns/10ps
module lccc_fifo #(
	parameter WIDTH = 144,
	parameter DEPTH = 16,
	parameter AW = 4
) (
	// Clock and reset.
	input wire clk,
	input wire rst_n,
	// Filling side.
	input wire in_valid,
	output wire in_ready,
	input wire [WIDTH-1:0] in_data,
	// Draining side.
	input wire out_ready,
	output wire out_valid,
	output reg [WIDTH-1:0] out_data,
	// Fill level.
	output reg [AW:0] level
);

reg [WIDTH-1:0] mem [0:DEPTH-1];
reg [AW-1:0] wr_ptr;
reg [AW-1:0] rd_ptr;
wire push;
wire pop;
wire [AW-1:0] head_addr;

// Full and empty come straight from the registered level.
assign in_ready = (level != DEPTH[AW:0]);
assign out_valid = (level != {(AW+1){1'b0}});
assign push = in_valid && in_ready;
assign pop = out_valid && out_ready;
assign head_addr = pop ? rd_ptr + 1'b1 : rd_ptr;

// Pointers and level.
always @(posedge clk or negedge rst_n)
begin
	if (!rst_n)
	begin
		wr_ptr <= {AW{1'b0}};
		rd_ptr <= {AW{1'b0}};
		level <= {(AW+1){1'b0}};
	end
	else
	begin
		if (push)
			wr_ptr <= wr_ptr + 1'b1;
		if (pop)
			rd_ptr <= head_addr;
		if (push && !pop)
			level <= level + 1'b1;
		else if (pop && !push)
			level <= level - 1'b1;
	end
end

// Storage; no reset is needed because empty words are never shown.
always @(posedge clk)
begin
	if (push)
		mem[wr_ptr] <= in_data;
end

// The head register bypasses a word written into the head slot.
always @(posedge clk or negedge rst_n)
begin
	if (!rst_n)
		out_data <= {WIDTH{1'b0}};
	else if (push && wr_ptr == head_addr)
		out_data <= in_data;
	else
		out_data <= mem[head_addr];
end

endmodule

/* verilog/lccc_sdft.v */
/*
 * Sliding one-period Fourier transform of one sample stream at the
 * fundamental, giving real and imaginary parts.
 * Assumes the caller supplies the common position in the period.
 */
`timescale 1ns/10ps
module lccc_sdft #(
	parameter XW = 17,
	parameter N = 16
) (
	// Clock and reset.
	input wire clk,
	input wire rst_n,
	// Sample in and its position in the period.
	input wire en,
	input wire [3:0] idx,
	input wire signed [XW-1:0] x,
	// Phasor out.
	output wire signed [XW+6:0] re,
	output wire signed [XW+6:0] im
);

localparam AW = XW + 21;

reg signed [XW-1:0] hist [0:N-1];
reg signed [AW-1:0] acc_re;
reg signed [AW-1:0] acc_im;
wire signed [XW:0] delta;
wire signed [15:0] c_w;
wire signed [15:0] s_w;
integer i;

// Cosine of 2*pi*k/16 in Q14; the sine is the same table shifted.
function signed [15:0] cos_q14;
	input [3:0] k;
	begin
		case (k[1:0] == 2'h0 ? 2'h0 : (k[2] ? 4'h8 - k[2:0] : k[2:0]))
			2'h0: cos_q14 = k[2] ? 16'h0000 : 16'h4000;
			2'h1: cos_q14 = 16'h3b21;
			2'h2: cos_q14 = 16'h2d41;
			2'h3: cos_q14 = 16'h187e;
			default: cos_q14 = 16'h0000;
		endcase
		if (k[3] ^ (k[2] & (k[1:0] != 2'h0)))
			cos_q14 = -cos_q14;
		if (k[2:0] == 3'h4)
			cos_q14 = 16'h0000;
		if (k == 4'h8)
			cos_q14 = 16'hc000;
	end
endfunction

assign delta = x - hist[idx];
assign c_w = cos_q14(idx);
assign s_w = cos_q14(idx - 4'h4);
assign re = acc_re[AW-1:14];
assign im = acc_im[AW-1:14];

// Old sample leaves and new one enters, so the window is exact.
always @(posedge clk or negedge rst_n)
begin
	if (!rst_n)
	begin
		acc_re <= {AW{1'b0}};
		acc_im <= {AW{1'b0}};
		for (i = 0; i < N; i = i + 1)
			hist[i] <= {XW{1'b0}};
	end
	else if (en)
	begin
		hist[idx] <= x;
		acc_re <= acc_re + delta * c_w;
		acc_im <= acc_im - delta * s_w;
	end
end

endmodule

/* verilog/lccc_top.v */
/*
 * Charging current compensator for line differential protection: voltage
 * differentiation, Fourier phasors, charging current and subtraction.
 * Assumes samples arrive from logic on MCLK, the block input from a pin,
 * and the compensated phasors are drained by the differential function.
 */
// The placing of the registers and register access over APB are this design's own decisions.
// Operation
// R1 - Each phase voltage derivative is the present sample minus the last.
// R2 - Charging current is capacitance times derivative, in sequence terms.
// R3 - Half of the line capacitance is taken at this end of the line.
// R4 - Both sequence capacitances follow from the reactance settings.
// R5 - Each line current gets its own Fourier transform.
// R6 - Three differentiators work on the three voltage sample streams.
// R7 - Each voltage derivative gets its own Fourier transform.
// R8 - The zero sequence voltage derivative gets a Fourier transform too.
// R9 - A charging phasor is formed for each of the three phases.
// R10 - Each output phasor is measured current minus charging current.
// R11 - An enable setting and a block input both gate compensation.
// R12 - When off or blocked the charging term is zero.
// R13 - Compensated phasors go to the differential function as its input.
// R14 - The enable setting is off or on and resets to off.
// R15 - Reactances span 100 to 2000 ohm in 0.1 ohm steps, default 500.
// R16 - Outside logic drives the block input high to stop compensation.
// R17 - All phasors use one period window and update on every sample.
`timescale 1ns/10ps
`include "lccc_defs.vh"
module lccc_top #(
	parameter SW = 16,
	parameter DEPTH = 16,
	parameter [31:0] KNUM = 32'h0200_0000,
	parameter SHIFT = 16
) (
	// Clock and reset.
	input wire MCLK,
	input wire RST_N,
	// APB slave.
	input wire PSEL,
	input wire PENABLE,
	input wire PWRITE,
	input wire [7:0] PADDR,
	input wire [31:0] PWDATA,
	output reg [31:0] PRDATA,
	output wire PREADY,
	output reg PSLVERR,
	// Sample stream.
	input wire SAMPLE_VALID,
	output wire SAMPLE_READY,
	input wire signed [SW-1:0] PHASE_CURRENT_A,
	input wire signed [SW-1:0] PHASE_CURRENT_B,
	input wire signed [SW-1:0] PHASE_CURRENT_C,
	input wire signed [SW-1:0] PHASE_VOLTAGE_A,
	input wire signed [SW-1:0] PHASE_VOLTAGE_B,
	input wire signed [SW-1:0] PHASE_VOLTAGE_C,
	// Block input from the pin.
	input wire COMPENSATION_BLOCK_INPUT,
	// Compensated phasors.
	output wire COMP_VALID,
	input wire COMP_READY,
	output wire signed [SW+7:0] COMP_A_RE,
	output wire signed [SW+7:0] COMP_A_IM,
	output wire signed [SW+7:0] COMP_B_RE,
	output wire signed [SW+7:0] COMP_B_IM,
	output wire signed [SW+7:0] COMP_C_RE,
	output wire signed [SW+7:0] COMP_C_IM
);

localparam XW = SW + 1;
localparam PW = SW + 8;
localparam S_IDLE = 3'b001;
localparam S_DIV1 = 3'b010;
localparam S_DIV0 = 3'b100;

// Settings and derived values.
reg compensation_enable_setting;
reg [15:0] positive_seq_reactance_setting;
reg [15:0] zero_seq_reactance_setting;
reg [31:0] recip1;
reg [31:0] recip0;
reg dirty;

// Divider state.
reg [2:0] state;
reg [2:0] next_state;
reg [31:0] quo;
reg [16:0] rem;
reg [5:0] step;

// Block input synchroniser.
reg blk_meta;
reg blk_sync;

// Pipeline.
reg signed [SW-1:0] prev_v [0:2];
reg signed [XW-1:0] s1_x [0:6];
reg s1_valid;
reg s2_valid;
reg [3:0] idx;

wire signed [SW-1:0] in_i [0:2];
wire signed [SW-1:0] in_v [0:2];
wire signed [PW-1:0] ph_re [0:6];
wire signed [PW-1:0] ph_im [0:6];
wire signed [XW+1:0] sum3;
wire signed [XW+17:0] third;
wire [6*PW-1:0] fifo_in;
wire [6*PW-1:0] fifo_out;
wire [4:0] level;
wire fifo_in_ready;
wire accept;
wire active;
wire setup;
wire [16:0] trial;
wire [15:0] divisor;
genvar g;

// Clamp a written reactance into its setting range.
function [15:0] clamp_xc;
	input [15:0] v;
	begin
		if (v < `LCCC_XC_MIN)
			clamp_xc = `LCCC_XC_MIN; // R15
		else if (v > `LCCC_XC_MAX)
			clamp_xc = `LCCC_XC_MAX; // R15
		else
			clamp_xc = v;
	end
endfunction

// Charging part of one phasor component, already half capacitance.
function signed [63:0] charge;
	input signed [PW-1:0] dphase;
	input signed [PW-1:0] dzero;
	input [31:0] r1;
	input [31:0] r0;
	reg signed [63:0] pos;
	reg signed [63:0] zer;
	begin
		pos = 64'sh0;
		zer = 64'sh0;
		pos = (dphase - dzero) * $signed({1'b0, r1}); // R2
		zer = dzero * $signed({1'b0, r0}); // R2
		charge = (pos + zer) >>> SHIFT;
	end
endfunction

assign in_i[0] = PHASE_CURRENT_A;
assign in_i[1] = PHASE_CURRENT_B;
assign in_i[2] = PHASE_CURRENT_C;
assign in_v[0] = PHASE_VOLTAGE_A;
assign in_v[1] = PHASE_VOLTAGE_B;
assign in_v[2] = PHASE_VOLTAGE_C;

// Room is kept for the two samples still in flight behind the FIFO.
assign SAMPLE_READY = (level <= DEPTH - 3);
assign accept = SAMPLE_VALID && SAMPLE_READY;
assign active = compensation_enable_setting && !blk_sync; // R11 R16
assign setup = PSEL && !PENABLE;
assign PREADY = 1'b1;

// The pin is caught by two flip-flops before anything looks at it.
always @(posedge MCLK or negedge RST_N)
begin
	if (!RST_N)
	begin
		blk_meta <= 1'b0;
		blk_sync <= 1'b0;
	end
	else
	begin
		blk_meta <= COMPENSATION_BLOCK_INPUT;
		blk_sync <= blk_meta;
	end
end

// Register writes take effect at the access edge; read data is latched
// in the setup cycle so the slave answers with no wait state.
always @(posedge MCLK or negedge RST_N)
begin
	if (!RST_N)
	begin
		compensation_enable_setting <= `LCCC_CTRL_RESET; // R14
		positive_seq_reactance_setting <= `LCCC_XC_RESET; // R15
		zero_seq_reactance_setting <= `LCCC_XC_RESET; // R15
		PRDATA <= 32'h0000_0000;
		PSLVERR <= 1'b0;
	end
	else
	begin
		if (PSEL && PENABLE && PWRITE)
		begin
			case (PADDR)
				`LCCC_OFS_CTRL:
					compensation_enable_setting <=
						PWDATA[`LCCC_CTRL_EN_BIT]; // R11
				`LCCC_OFS_XC1:
					positive_seq_reactance_setting <=
						clamp_xc(PWDATA[15:0]);
				`LCCC_OFS_XC0:
					zero_seq_reactance_setting <=
						clamp_xc(PWDATA[15:0]);
				default:
					PSLVERR <= PSLVERR;
			endcase
		end
		if (setup)
		begin
			PSLVERR <= 1'b0;
			PRDATA <= 32'h0000_0000;
			case (PADDR)
				`LCCC_OFS_CTRL:
					PRDATA[`LCCC_CTRL_EN_BIT] <=
						compensation_enable_setting;
				`LCCC_OFS_XC1:
					PRDATA[15:0] <= positive_seq_reactance_setting;
				`LCCC_OFS_XC0:
					PRDATA[15:0] <= zero_seq_reactance_setting;
				`LCCC_OFS_STATUS:
				begin
					PRDATA[`LCCC_ST_ACTIVE_BIT] <= active;
					PRDATA[`LCCC_ST_BLOCK_BIT] <= blk_sync;
					PRDATA[`LCCC_ST_BUSY_BIT] <= (state != S_IDLE);
					PRDATA[`LCCC_ST_LEVEL_LSB+4:`LCCC_ST_LEVEL_LSB] <=
						level;
				end
				`LCCC_OFS_RECIP1:
					PRDATA <= recip1;
				`LCCC_OFS_RECIP0:
					PRDATA <= recip0;
				default:
					PSLVERR <= 1'b1;
			endcase
		end
	end
end

// A reactance write marks the capacitances stale; the set wins.
always @(posedge MCLK or negedge RST_N)
begin
	if (!RST_N)
		dirty <= 1'b1;
	else if (PSEL && PENABLE && PWRITE &&
		(PADDR == `LCCC_OFS_XC1 || PADDR == `LCCC_OFS_XC0))
		dirty <= 1'b1;
	else if (state == S_IDLE)
		dirty <= 1'b0;
end

// The divider state machine runs on both reactances in turn.
always @*
begin
	next_state = state;
	case (state)
		S_IDLE:
			if (dirty)
				next_state = S_DIV1;
		S_DIV1:
			if (step == `LCCC_DIV_STEPS)
				next_state = S_DIV0;
		S_DIV0:
			if (step == `LCCC_DIV_STEPS)
				next_state = S_IDLE;
		default:
			next_state = S_IDLE;
	endcase
end

assign divisor = (state == S_DIV1) ? positive_seq_reactance_setting :
	zero_seq_reactance_setting;
assign trial = {rem[15:0], quo[31]};

// Restoring division of KNUM by the reactance gives half the line
// capacitance per sample step; a serial divider saves a large array.
always @(posedge MCLK or negedge RST_N)
begin
	if (!RST_N)
	begin
		state <= S_IDLE;
		quo <= 32'h0000_0000;
		rem <= 17'h00000;
		step <= 6'h00;
		recip1 <= 32'h0000_0000;
		recip0 <= 32'h0000_0000;
	end
	else
	begin
		state <= next_state;
		if (state == S_IDLE || step == `LCCC_DIV_STEPS)
		begin
			quo <= KNUM;
			rem <= 17'h00000;
			step <= 6'h00;
			if (state == S_DIV1)
				recip1 <= quo; // R4 R3
			if (state == S_DIV0)
				recip0 <= quo; // R4 R3
		end
		else
		begin
			step <= step + 6'h01;
			if (trial >= {1'b0, divisor})
			begin
				rem <= trial - {1'b0, divisor};
				quo <= {quo[30:0], 1'b1};
			end
			else
			begin
				rem <= trial;
				quo <= {quo[30:0], 1'b0};
			end
		end
	end
end

// Stage one: voltage differences and aligned current samples.
always @(posedge MCLK or negedge RST_N)
begin
	if (!RST_N)
	begin
		s1_valid <= 1'b0;
		s2_valid <= 1'b0;
		idx <= 4'h0;
	end
	else
	begin
		s1_valid <= accept;
		s2_valid <= s1_valid;
		if (s1_valid)
			idx <= idx + 4'h1; // R17
	end
end

generate
	for (g = 0; g < 3; g = g + 1)
	begin : g_diff
		// Differentiator of one phase voltage.
		always @(posedge MCLK or negedge RST_N)
		begin
			if (!RST_N)
			begin
				prev_v[g] <= {SW{1'b0}};
				s1_x[g] <= {XW{1'b0}};
				s1_x[g+3] <= {XW{1'b0}};
			end
			else if (accept)
			begin
				prev_v[g] <= in_v[g]; // R6
				s1_x[g] <= in_v[g] - prev_v[g]; // R1
				s1_x[g+3] <= in_i[g];
			end
		end
	end
endgenerate

// The zero sequence derivative is a third of the summed derivatives.
assign sum3 = in_v[0] - prev_v[0] + in_v[1] - prev_v[1] +
	in_v[2] - prev_v[2];
assign third = sum3 * $signed({1'b0, `LCCC_THIRD_Q16});

always @(posedge MCLK or negedge RST_N)
begin
	if (!RST_N)
		s1_x[6] <= {XW{1'b0}};
	else if (accept)
		s1_x[6] <= third[XW+15:16]; // R8
end

// Seven transforms share one window position, so phasors line up.
generate
	for (g = 0; g < 7; g = g + 1)
	begin : g_dft
		lccc_sdft #(
			.XW(XW),
			.N(`LCCC_NPER)
		) u_dft (
			.clk(MCLK),
			.rst_n(RST_N),
			.en(s1_valid), // R5 R7 R17
			.idx(idx),
			.x(s1_x[g]),
			.re(ph_re[g]),
			.im(ph_im[g])
		);
	end
endgenerate

// Stage two: per phase charging phasor, zero when not active.
generate
	for (g = 0; g < 3; g = g + 1)
	begin : g_comp
		wire signed [63:0] ic_re;
		wire signed [63:0] ic_im;
		wire signed [63:0] out_re;
		wire signed [63:0] out_im;
		assign ic_re = active ? charge(ph_re[g], ph_re[6], recip1, recip0) :
			64'sh0; // R9 R12
		assign ic_im = active ? charge(ph_im[g], ph_im[6], recip1, recip0) :
			64'sh0; // R9 R12
		assign out_re = ph_re[g+3] - ic_re; // R10
		assign out_im = ph_im[g+3] - ic_im; // R10
		assign fifo_in[2*g*PW +: PW] = out_re[PW-1:0];
		assign fifo_in[(2*g+1)*PW +: PW] = out_im[PW-1:0];
	end
endgenerate

// Compensated phasors queue for the differential function.
lccc_fifo #(
	.WIDTH(6*PW),
	.DEPTH(DEPTH),
	.AW(4)
) u_fifo (
	.clk(MCLK),
	.rst_n(RST_N),
	.in_valid(s2_valid),
	.in_ready(fifo_in_ready),
	.in_data(fifo_in),
	.out_ready(COMP_READY), // R13
	.out_valid(COMP_VALID),
	.out_data(fifo_out),
	.level(level)
);

assign COMP_A_RE = fifo_out[0*PW +: PW];
assign COMP_A_IM = fifo_out[1*PW +: PW];
assign COMP_B_RE = fifo_out[2*PW +: PW];
assign COMP_B_IM = fifo_out[3*PW +: PW];
assign COMP_C_RE = fifo_out[4*PW +: PW];
assign COMP_C_IM = fifo_out[5*PW +: PW];

endmodule

/* sim/lccc_chk_assertions.sv */
/* Port checker for the charging current compensator top.
   Assumes one clock, MCLK, and an active low asynchronous reset. */
`timescale 1ns/10ps
module lccc_chk #(parameter SW = 16) (
	// Clock and reset.
	input wire MCLK,
	input wire RST_N,
	// Register bus.
	input wire PSEL,
	input wire PENABLE,
	input wire PWRITE,
	input wire [7:0] PADDR,
	input wire [31:0] PRDATA,
	input wire PREADY,
	input wire PSLVERR,
	// Sample and phasor streams.
	input wire SAMPLE_VALID,
	input wire SAMPLE_READY,
	input wire COMP_VALID,
	input wire COMP_READY,
	input wire signed [SW+7:0] COMP_A_RE,
	input wire signed [SW+7:0] COMP_C_IM
);
	default clocking @(posedge MCLK); endclocking
	default disable iff (!RST_N);
	// Access decode; the six words sit on aligned addresses up to 0x14.
	wire acc = PSEL && PENABLE;
	wire rd = acc && !PWRITE;
	wire map = PADDR <= 8'h14 && PADDR[1:0] == 2'b00;
	wire take = SAMPLE_VALID && SAMPLE_READY;
	sequence s_take;
		take && !COMP_VALID;
	endsequence
	sequence s_quiet;
		!take && !COMP_VALID;
	endsequence
	property p_rdy; acc |-> PREADY; endproperty
	property p_err; acc |-> PSLVERR == !map; endproperty
	property p_unm; rd && !map |-> PRDATA == 32'h0; endproperty
	property p_xc;
		rd && (PADDR == 8'h04 || PADDR == 8'h08)
			|-> PRDATA >= 32'h3e8 && PRDATA <= 32'h4e20;
	endproperty
	property p_ctl; rd && PADDR == 8'h00 |-> PRDATA[31:1] == 31'h0; endproperty
	property p_hold;
		COMP_VALID && !COMP_READY |=> COMP_VALID && $stable(COMP_A_RE)
			&& $stable(COMP_C_IM);
	endproperty
	property p_first; s_take |-> ##[2:4] COMP_VALID; endproperty
	property p_idle; s_quiet [*4] |=> !COMP_VALID; endproperty
	property p_srdy; !COMP_VALID |-> SAMPLE_READY; endproperty
	a_rdy: assert property (p_rdy) else $error("bus not ready");
	a_err: assert property (p_err) else $error("wrong slave error");
	a_unm: assert property (p_unm) else $error("unmapped read not zero");
	a_xc: assert property (p_xc) else $error("reactance out of range");
	a_ctl: assert property (p_ctl) else $error("enable has extra bits");
	a_hold: assert property (p_hold) else $error("phasor not held");
	a_first: assert property (p_first) else $error("no phasor out");
	a_idle: assert property (p_idle) else $error("phasor from nowhere");
	a_srdy: assert property (p_srdy) else $error("empty yet refusing");
endmodule
bind lccc_top lccc_chk #(.SW(SW)) i_chk (.MCLK(MCLK), .RST_N(RST_N),
	.PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
	.PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
	.SAMPLE_VALID(SAMPLE_VALID), .SAMPLE_READY(SAMPLE_READY),
	.COMP_VALID(COMP_VALID), .COMP_READY(COMP_READY),
	.COMP_A_RE(COMP_A_RE), .COMP_C_IM(COMP_C_IM));

/* sim/lccc_sink.sv */
/* Model of the differential function that drains the compensated phasors.
   Assumes one clock; stall holds ready low so the FIFO backs up. */
`timescale 1ns/10ps
module lccc_sink #(parameter W = 24) (
	// Clock, reset and bench controls.
	input wire clk,
	input wire rst_n,
	input wire stall,
	input wire clr,
	// Phasor stream, phases A, B, C with real then imaginary.
	input wire valid,
	output reg ready,
	input wire [6*W-1:0] word,
	// Which phases carried a nonzero phasor, and the count taken.
	output reg [2:0] nz,
	output integer pops
);
	initial nz = 3'b000;
	initial pops = 0;
	// Ready moves just after a rising edge, as the real consumer does.
	always @(posedge clk or negedge rst_n)
		if (!rst_n)
			ready <= 1'b0;
		else
			ready <= !stall;
	// Transfers are judged at the rising edge that completes them.
	always @(posedge clk)
	begin
		if (valid && ready)
			pops <= pops + 1;
		if (clr)
			nz <= 3'b000;
		else if (valid && ready)
			nz <= nz | {|word[6*W-1:4*W], |word[4*W-1:2*W], |word[2*W-1:0]};
	end
endmodule

/* sim/tb_top.sv */
/* Bench for the compensator: register checks, phasor scenarios, full FIFO.
   Assumes the sink model and the bound checker are compiled beside it. */
`timescale 1ns/10ps
module tb_top;
	localparam [31:0] KN = 32'h0200_0000;
	reg MCLK = 1'b0, RST_N = 1'b0, PSEL = 1'b0, PENABLE = 1'b0;
	reg PWRITE = 1'b0, SAMPLE_VALID = 1'b0, blk = 1'b0;
	reg stall = 1'b0, clr = 1'b0, acc = 1'b0, e;
	reg [7:0] PADDR = 8'h00;
	reg [31:0] PWDATA = 32'h0, q;
	reg signed [15:0] ca = 16'h0, cb = 16'h0, cc = 16'h0;
	reg signed [15:0] va = 16'h0, vb = 16'h0, vc = 16'h0;
	wire [31:0] PRDATA;
	wire PREADY, PSLVERR, SAMPLE_READY, COMP_VALID, COMP_READY;
	wire signed [23:0] ar, ai, br, bi, cr, ci;
	wire [2:0] nz;
	integer pops, failures = 0, checked = 0, na, base, n;
	lccc_top #(.KNUM(KN)) i_dut (.MCLK(MCLK), .RST_N(RST_N), .PSEL(PSEL),
		.PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
		.PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
		.PSLVERR(PSLVERR), .SAMPLE_VALID(SAMPLE_VALID),
		.SAMPLE_READY(SAMPLE_READY), .PHASE_CURRENT_A(ca),
		.PHASE_CURRENT_B(cb), .PHASE_CURRENT_C(cc), .PHASE_VOLTAGE_A(va),
		.PHASE_VOLTAGE_B(vb), .PHASE_VOLTAGE_C(vc),
		.COMPENSATION_BLOCK_INPUT(blk), .COMP_VALID(COMP_VALID),
		.COMP_READY(COMP_READY), .COMP_A_RE(ar), .COMP_A_IM(ai),
		.COMP_B_RE(br), .COMP_B_IM(bi), .COMP_C_RE(cr), .COMP_C_IM(ci));
	lccc_sink i_sink (.clk(MCLK), .rst_n(RST_N), .stall(stall), .clr(clr),
		.valid(COMP_VALID), .ready(COMP_READY),
		.word({ar, ai, br, bi, cr, ci}), .nz(nz), .pops(pops));
	// A 200 MHz clock.
	always #2.5 MCLK = ~MCLK;
	task chk(input string nm, input [31:0] x, input [31:0] g);
	begin
		checked = checked + 1;
		if (g !== x)
		begin
			failures = failures + 1;
			$display("mismatch %0s expected %h seen %h", nm, x, g);
		end
	end
	endtask
	// Ready, read data and error are taken at the access edge itself; the
	// registered outputs still show their old values in that time step.
	task apb(input w, input [7:0] a, input [31:0] d);
	reg r;
	integer k;
	begin
		@(posedge MCLK);
		PSEL <= 1'b1;
		PENABLE <= 1'b0;
		PWRITE <= w;
		PADDR <= a;
		PWDATA <= d;
		@(posedge MCLK);
		PENABLE <= 1'b1;
		r = 1'b0;
		for (k = 0; k < 50 && r !== 1'b1; k = k + 1)
		begin
			@(posedge MCLK);
			r = PREADY;
			q = PRDATA;
			e = PSLVERR;
		end
		chk("ready", 32'h1, {31'h0, r});
		PSEL <= 1'b0;
		PENABLE <= 1'b0;
	end
	endtask
	task rd(input [7:0] a, input [31:0] m, input [31:0] x, input er);
	begin
		apb(1'b0, a, 32'h0);
		chk("read data", x, q & m);
		chk("read error", {31'h0, er}, {31'h0, e});
	end
	endtask
	task wr(input [7:0] a, input [31:0] d, input er);
	begin
		apb(1'b1, a, d);
		chk("write error", {31'h0, er}, {31'h0, e});
	end
	endtask
	// The coefficient divider must settle before charging is trusted.
	task waitdiv;
	begin
		q = 32'h4;
		for (n = 0; n < 100 && q[2] !== 1'b0; n = n + 1)
			apb(1'b0, 8'h0c, 32'h0);
		chk("divider busy", 32'h0, {31'h0, q[2]});
	end
	endtask
	// A square wave keeps the fundamental strong with exact integer sums.
	function signed [15:0] sq(input integer k);
		sq = k[3] ? 16'hfc18 : 16'h03e8;
	endfunction
	// One attempt at one sample set; data stay put while it is refused.
	task put(input integer k, input [2:0] im, input vo);
	begin
		SAMPLE_VALID <= 1'b1;
		clr <= (k == 20);
		ca <= im[2] ? sq(k) : 16'h0000;
		cb <= im[1] ? sq(k) : 16'h0000;
		cc <= im[0] ? sq(k) : 16'h0000;
		va <= vo ? sq(k) : 16'h0400;
		vb <= vo ? sq(k + 5) : 16'h0400;
		vc <= vo ? sq(k + 11) : 16'h0400;
		// Ready is judged at the edge that takes the sample.
		@(posedge MCLK);
		acc = SAMPLE_READY;
	end
	endtask
	task drain;
	begin
		SAMPLE_VALID <= 1'b0;
		stall <= 1'b0;
		repeat (4) @(posedge MCLK);
		for (n = 0; n < 60 && COMP_VALID !== 1'b0; n = n + 1)
			@(negedge MCLK);
		@(posedge MCLK);
	end
	endtask
	// Twenty samples settle the window, the rest are judged by the sink.
	task run(input [2:0] im, input vo, input [2:0] x);
	integer k;
	begin
		@(posedge MCLK);
		for (k = 0; k < 36; k = k + 1)
		begin
			acc = 1'b0;
			while (acc !== 1'b1)
				put(k, im, vo);
		end
		drain;
		chk("nonzero phases", {29'h0, x}, {29'h0, nz});
	end
	endtask
	task close_out;
	begin
		$display("checked %0d failures %0d", checked, failures);
		if (failures == 0 && checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	end
	endtask
	// The whole run needs well under a thousand cycles; this limit allows 20000.
	initial
	begin
		#100000;
		failures = failures + 1;
		close_out;
	end
	initial
	begin
		repeat (2) @(posedge MCLK);
		RST_N <= 1'b1;
		rd(8'h00, 32'h1, 32'h0, 1'b0);
		rd(8'h04, 32'hffff, 32'h1388, 1'b0);
		rd(8'h08, 32'hffff, 32'h1388, 1'b0);
		rd(8'h18, 32'hffffffff, 32'h0, 1'b1);
		wr(8'h20, 32'h1, 1'b1);
		waitdiv;
		rd(8'h10, 32'hffffffff, KN / 32'h1388, 1'b0);
		run(3'b000, 1'b1, 3'b000);
		run(3'b100, 1'b1, 3'b100);
		wr(8'h00, 32'h1, 1'b0);
		rd(8'h0c, 32'h3, 32'h1, 1'b0);
		run(3'b000, 1'b0, 3'b000);
		run(3'b000, 1'b1, 3'b111);
		blk <= 1'b1;
		repeat (3) @(posedge MCLK);
		rd(8'h0c, 32'h3, 32'h2, 1'b0);
		run(3'b000, 1'b1, 3'b000);
		blk <= 1'b0;
		wr(8'h04, 32'hffff, 1'b0);
		rd(8'h04, 32'hffffffff, 32'h4e20, 1'b0);
		wr(8'h08, 32'h0, 1'b0);
		rd(8'h08, 32'hffffffff, 32'h3e8, 1'b0);
		waitdiv;
		rd(8'h10, 32'hffffffff, KN / 32'h4e20, 1'b0);
		rd(8'h14, 32'hffffffff, KN / 32'h3e8, 1'b0);
		stall <= 1'b1;
		base = pops;
		na = 0;
		for (n = 0; n < 30; n = n + 1)
		begin
			put(na, 3'b111, 1'b1);
			na = na + acc;
		end
		chk("fill bound", 32'h1, {31'h0, na >= 14 && na <= 16});
		drain;
		chk("drained", na, pops - base);
		close_out;
	end
endmodule
